// ==== verilog/asf_pkg.sv ====
// Constants and types shared by the accelerometer sample buffer
package asf_pkg;
   // Storage shape
   localparam int unsigned DEPTH = 32;
   localparam int unsigned SAMPLE_W = 16;
   localparam int unsigned IDX_W = 5;
   localparam int unsigned LVL_W = 6;
   localparam logic [5:0] FULL_LEVEL = 6'h20;
   localparam logic [4:0] LEVEL_SAT = 5'h1f;
   localparam int unsigned ADDR_W = 8;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PIN_CTRL = 8'h23;
   localparam logic [7:0] IDX_BUF_CTRL = 8'h25;
   localparam logic [7:0] IDX_OUT_XL = 8'h28;
   localparam logic [7:0] IDX_OUT_XH = 8'h29;
   localparam logic [7:0] IDX_OUT_YL = 8'h2a;
   localparam logic [7:0] IDX_OUT_YH = 8'h2b;
   localparam logic [7:0] IDX_OUT_ZL = 8'h2c;
   localparam logic [7:0] IDX_OUT_ZH = 8'h2d;
   localparam logic [7:0] IDX_MODE_CTRL = 8'h2e;
   localparam logic [7:0] IDX_SOURCE = 8'h2f;

   // Pin control register fields
   localparam int unsigned PIN1_EN_BIT = 0;
   localparam int unsigned PIN2_EN_BIT = 1;
   localparam int unsigned PIN2_EMPTY_BIT = 2;
   localparam int unsigned PIN2_WTM_BIT = 3;
   localparam int unsigned PIN2_OVR_BIT = 4;

   // Buffer control register fields
   localparam int unsigned EMPTY_ROUTE_BIT = 0;
   localparam int unsigned OVR_ROUTE_BIT = 1;
   localparam int unsigned WTM_ROUTE_BIT = 2;
   localparam int unsigned WATERMARK_ENABLE_BIT = 5;
   localparam int unsigned BUF_EN_BIT = 6;

   // Mode control register fields
   localparam int unsigned THR_LSB = 0;
   localparam int unsigned MODE_LSB = 5;

   // Source register fields
   localparam int unsigned SRC_EMPTY_BIT = 5;
   localparam int unsigned SRC_OVR_BIT = 6;
   localparam int unsigned SRC_WTM_BIT = 7;

   // Reset values
   localparam logic [7:0] PIN_CTRL_RST = 8'h00;
   localparam logic [7:0] BUF_CTRL_RST = 8'h00;
   localparam logic [7:0] MODE_CTRL_RST = 8'h00;

   // Mode codes; only the fifo code is fixed, the rest are defaults
   localparam logic [2:0] MODE_BYPASS = 3'h0;
   localparam logic [2:0] MODE_FIFO = 3'h1;
   localparam logic [2:0] MODE_STREAM = 3'h2;
   localparam logic [2:0] MODE_S2F = 3'h3;
   localparam logic [2:0] MODE_B2S = 3'h4;

   // Effective behaviour of the buffer
   typedef enum logic [1:0] {bh_bypass, bh_fifo, bh_stream} asf_behav_t;

   // Register index to byte address
   function automatic logic [ADDR_W-1:0] asf_byte_addr(input logic [7:0] idx);
      return {idx[5:0], 2'b00};
   endfunction : asf_byte_addr
endpackage : asf_pkg

// ==== verilog/asf_slot_store.sv ====
// Flip-flop storage of sample sets, one slot per index
`timescale 1ns/1ps
module asf_slot_store #(
   parameter int unsigned WIDTH = 48,
   parameter int unsigned DEPTH = 32,
   parameter int unsigned IDX_W = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic wr_en,
   input wire logic [IDX_W-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [IDX_W-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] slot_q [DEPTH];

   // One register per slot, written when its index is addressed
   for (genvar g = 0; g < DEPTH; g++) begin : g_slot
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            slot_q[g] <= '0;
         end else if (en && wr_en && wr_idx == IDX_W'(g)) begin
            slot_q[g] <= wr_data;
         end
      end
   end

   // Oldest-set read port
   assign rd_data = slot_q[rd_idx];
endmodule : asf_slot_store

// ==== verilog/asf_sample_buffer.sv ====
// Accelerometer three-channel sample buffer with APB registers
//
// Function
// RULE1: Thirty-two slots per channel, one X/Y/Z set per slot.
// RULE2: Buffering only while the buffer enable bit at 25h is set.
// RULE3: Three-bit mode field at 2Eh selects one of five modes.
// RULE4: Watermark, empty, overrun events reach both pins, each pin gated at 23h.
// RULE5: Empty flag at 2Fh reads one when nothing is stored.
// RULE6: Watermark flag sets on arrival when level is at least threshold.
// RULE7: Watermark flag clears on readout when level is at most threshold.
// RULE8: All slots full gives overrun flag one; next set overwrites a slot.
// RULE9: Bypass stores nothing, stays empty, first slot takes each new sample.
// RULE10: Host writes bypass mode to clear the buffer.
// RULE11: Fifo mode stores until full, then stops and keeps content.
// RULE12: Overrun interrupt, enabled at 25h, raised when collection stops on full.
// RULE13: At overrun the first set is overwritten and collection stops; the code stops without overwriting, so the first set is kept.
// RULE14: Host passes through bypass, then writes 001 to restart fifo mode.
// RULE15: Watermark enable at 25h reduces depth to the five-bit threshold; the code limits it to the threshold plus one.
// RULE16: Watermark reaches pin one only when its routing bit at 25h is set.
// RULE17: Stream mode wraps when full, overwriting oldest sets until reads free slots.
// RULE18: Stream-to-fifo acts as fifo while engine bits are one, else stream.
// RULE19: Reading 28h to 2Dh presents the oldest set, single or burst.
// RULE20: Mode codes besides fifo are parameters; unlisted codes act as bypass.
// RULE21: Stored count saturates at five bits; overrun flag marks full.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module asf_sample_buffer
   import asf_pkg::*;
#(
   parameter int unsigned SAMPLE_WIDTH = asf_pkg::SAMPLE_W,
   parameter logic [2:0] CODE_BYPASS = asf_pkg::MODE_BYPASS,
   parameter logic [2:0] CODE_STREAM = asf_pkg::MODE_STREAM,
   parameter logic [2:0] CODE_S2F = asf_pkg::MODE_S2F,
   parameter logic [2:0] CODE_B2S = asf_pkg::MODE_B2S
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [asf_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_valid,
   input wire logic [SAMPLE_WIDTH-1:0] sample_x,
   input wire logic [SAMPLE_WIDTH-1:0] sample_y,
   input wire logic [SAMPLE_WIDTH-1:0] sample_z,
   input wire logic engine_one_irq_bit,
   input wire logic engine_two_irq_bit,
   output logic accel_irq_pin_one,
   output logic accel_irq_pin_two
);
   import asf_pkg::*;
   localparam int unsigned SET_W = 3 * SAMPLE_WIDTH;
   // Address hit on a register index
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
      return addr == asf_byte_addr(idx);
   endfunction : reg_hit
   logic [7:0] irq_pin_control_register_q;
   logic [7:0] buffer_control_register_q;
   logic [7:0] mode_ctrl_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic pin_one_q;
   logic pin_two_q;
   logic [IDX_W-1:0] wr_idx_q;
   logic [IDX_W-1:0] rd_idx_q;
   logic [LVL_W-1:0] level_q;
   logic [LVL_W-1:0] lvl_nxt;
   logic watermark_flag_q;
   logic halted_q;
   logic b2s_armed_q;
   logic [SET_W-1:0] head_set;
   logic [SET_W-1:0] in_set;
   asf_behav_t behav;
   // Control fields
   logic first_irq_pin_enable;
   logic second_irq_pin_enable;
   logic buffer_enable;
   logic watermark_enable;
   logic watermark_irq_route;
   logic overrun_irq_route;
   logic empty_irq_route;
   logic [2:0] buffer_mode_field;
   logic [4:0] watermark_threshold;
   assign first_irq_pin_enable = irq_pin_control_register_q[PIN1_EN_BIT];
   assign second_irq_pin_enable = irq_pin_control_register_q[PIN2_EN_BIT];
   assign buffer_enable = buffer_control_register_q[BUF_EN_BIT];
   assign watermark_enable = buffer_control_register_q[WATERMARK_ENABLE_BIT];
   assign watermark_irq_route = buffer_control_register_q[WTM_ROUTE_BIT];
   assign overrun_irq_route = buffer_control_register_q[OVR_ROUTE_BIT];
   assign empty_irq_route = buffer_control_register_q[EMPTY_ROUTE_BIT];
   assign buffer_mode_field = mode_ctrl_q[MODE_LSB +: 3];
   assign watermark_threshold = mode_ctrl_q[THR_LSB +: 5];
   // APB phases
   logic setup;
   logic access;
   logic wr_acc;
   logic mapped;
   logic pop_req;
   assign setup = psel && !penable;
   assign access = psel && penable && pready_q;
   assign wr_acc = access && pwrite;
   assign pop_req = access && !pwrite && reg_hit(paddr, IDX_OUT_ZH);
   assign mapped = reg_hit(paddr, IDX_PIN_CTRL) || reg_hit(paddr, IDX_BUF_CTRL) ||
                   reg_hit(paddr, IDX_MODE_CTRL) || reg_hit(paddr, IDX_SOURCE) ||
                   (paddr >= asf_byte_addr(IDX_OUT_XL) && paddr <= asf_byte_addr(IDX_OUT_ZH) &&
                    paddr[1:0] == 2'b00);
   // Either engine flag acts as the trigger
   logic trig;
   assign trig = engine_one_irq_bit || engine_two_irq_bit;
   // Effective behaviour from enable, mode code and trigger
   always_comb begin
      behav = bh_bypass;
      if (buffer_enable) begin // RULE2
         if (buffer_mode_field == CODE_BYPASS) begin
            behav = bh_bypass; // RULE9
         end else if (buffer_mode_field == MODE_FIFO) begin // RULE3
            behav = bh_fifo;
         end else if (buffer_mode_field == CODE_STREAM) begin // RULE20
            behav = bh_stream;
         end else if (buffer_mode_field == CODE_S2F) begin
            behav = trig ? bh_fifo : bh_stream; // RULE18
         end else if (buffer_mode_field == CODE_B2S) begin
            behav = b2s_armed_q ? bh_stream : bh_bypass;
         end else begin
            behav = bh_bypass; // RULE20
         end
      end
   end
   // Occupancy, limit and handshakes of the ring
   logic [LVL_W-1:0] depth_lim;
   logic full;
   logic empty;
   logic push;
   logic pop;
   assign depth_lim = watermark_enable ? ({1'b0, watermark_threshold} + 6'h01) : FULL_LEVEL; // RULE15
   assign full = level_q >= depth_lim; // RULE8
   assign empty = level_q == '0; // RULE5
   assign push = sample_valid && behav != bh_bypass &&
                 !(behav == bh_fifo && (full || halted_q)); // RULE11 RULE13
   assign pop = pop_req && behav != bh_bypass && !empty; // RULE19
   // Next level: stream overwrite on full keeps the level
   always_comb begin
      lvl_nxt = level_q;
      if (push && !pop && !full) begin
         lvl_nxt = level_q + 6'h01;
      end else if (pop && !push) begin
         lvl_nxt = level_q - 6'h01;
      end
   end
   // Sample storage; bypass keeps writing the first slot
   assign in_set = {sample_z, sample_y, sample_x};
   asf_slot_store #(
      .WIDTH(SET_W),
      .DEPTH(DEPTH),
      .IDX_W(IDX_W)
   ) u_store (
      .clk(pclk),
      .rst_n(presetn),
      .en(ce),
      .wr_en(push || (sample_valid && behav == bh_bypass)), // RULE9
      .wr_idx(behav == bh_bypass ? '0 : wr_idx_q), // RULE1
      .wr_data(in_set),
      .rd_idx(rd_idx_q),
      .rd_data(head_set)
   );
   // Ring pointers and level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_idx_q <= '0;
         rd_idx_q <= '0;
         level_q <= '0;
      end else if (ce) begin
         if (behav == bh_bypass) begin
            wr_idx_q <= '0; // RULE9
            rd_idx_q <= '0;
            level_q <= '0;
         end else begin
            if (push) begin
               wr_idx_q <= wr_idx_q + 5'h01; // RULE17
            end
            if (pop || (push && full)) begin
               rd_idx_q <= rd_idx_q + 5'h01; // RULE17
            end
            level_q <= lvl_nxt;
         end
      end
   end
   // Fifo-mode stop latch, released only through bypass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halted_q <= 1'b0;
      end else if (ce) begin
         if (behav == bh_bypass) begin
            halted_q <= 1'b0;
         end else if (behav == bh_fifo && sample_valid && full) begin
            halted_q <= 1'b1; // RULE13
         end
      end
   end
   // Trigger latch for bypass-to-stream
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b2s_armed_q <= 1'b0;
      end else if (ce) begin
         if (!buffer_enable || buffer_mode_field != CODE_B2S) begin
            b2s_armed_q <= 1'b0;
         end else if (trig) begin
            b2s_armed_q <= 1'b1;
         end
      end
   end
   // Watermark flag; arrival set wins over readout clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watermark_flag_q <= 1'b0;
      end else if (ce) begin
         if (behav == bh_bypass) begin
            watermark_flag_q <= 1'b0;
         end else if (push && lvl_nxt >= {1'b0, watermark_threshold}) begin
            watermark_flag_q <= 1'b1; // RULE6
         end else if (pop && lvl_nxt <= {1'b0, watermark_threshold}) begin
            watermark_flag_q <= 1'b0; // RULE7
         end
      end
   end
   // Control register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_pin_control_register_q <= PIN_CTRL_RST;
         buffer_control_register_q <= BUF_CTRL_RST;
         mode_ctrl_q <= MODE_CTRL_RST;
      end else if (ce && wr_acc) begin
         if (reg_hit(paddr, IDX_PIN_CTRL)) begin
            irq_pin_control_register_q <= pwdata[7:0];
         end
         if (reg_hit(paddr, IDX_BUF_CTRL)) begin
            buffer_control_register_q <= pwdata[7:0];
         end
         if (reg_hit(paddr, IDX_MODE_CTRL)) begin
            mode_ctrl_q <= pwdata[7:0];
         end
      end
   end

   // Source register view; count saturates, overrun marks full
   logic [7:0] source_view;
   assign source_view = {watermark_flag_q, full, empty,
                         (level_q >= FULL_LEVEL) ? LEVEL_SAT : level_q[4:0]}; // RULE21

   // Read data mux
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      if (reg_hit(paddr, IDX_PIN_CTRL)) begin
         rd_mux[7:0] = irq_pin_control_register_q;
      end else if (reg_hit(paddr, IDX_BUF_CTRL)) begin
         rd_mux[7:0] = buffer_control_register_q;
      end else if (reg_hit(paddr, IDX_MODE_CTRL)) begin
         rd_mux[7:0] = mode_ctrl_q;
      end else if (reg_hit(paddr, IDX_SOURCE)) begin
         rd_mux[7:0] = source_view; // RULE5
      end else if (reg_hit(paddr, IDX_OUT_XL)) begin
         rd_mux[7:0] = head_set[7:0]; // RULE19
      end else if (reg_hit(paddr, IDX_OUT_XH)) begin
         rd_mux[7:0] = head_set[15:8];
      end else if (reg_hit(paddr, IDX_OUT_YL)) begin
         rd_mux[7:0] = head_set[SAMPLE_WIDTH +: 8];
      end else if (reg_hit(paddr, IDX_OUT_YH)) begin
         rd_mux[7:0] = head_set[SAMPLE_WIDTH+8 +: 8];
      end else if (reg_hit(paddr, IDX_OUT_ZL)) begin
         rd_mux[7:0] = head_set[2*SAMPLE_WIDTH +: 8];
      end else if (reg_hit(paddr, IDX_OUT_ZH)) begin
         rd_mux[7:0] = head_set[2*SAMPLE_WIDTH+8 +: 8];
      end
   end

   // APB answer: one access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else if (ce) begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // Interrupt pins, each gated by its own enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_one_q <= 1'b0;
         pin_two_q <= 1'b0;
      end else if (ce) begin
         pin_one_q <= first_irq_pin_enable && ((watermark_irq_route && watermark_flag_q) || // RULE16
                      (overrun_irq_route && full && behav != bh_bypass) || // RULE12
                      (empty_irq_route && empty)); // RULE4
         pin_two_q <= second_irq_pin_enable &&
                      ((irq_pin_control_register_q[PIN2_WTM_BIT] && watermark_flag_q) ||
                       (irq_pin_control_register_q[PIN2_OVR_BIT] && full && behav != bh_bypass) ||
                       (irq_pin_control_register_q[PIN2_EMPTY_BIT] && empty)); // RULE4
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign accel_irq_pin_one = pin_one_q;
   assign accel_irq_pin_two = pin_two_q;

   // Checks beside the logic
   level_cap_a: assert property ( // RULE1
      @(posedge pclk) disable iff (!presetn) level_q <= FULL_LEVEL)
      else $error("level above thirty-two");
   disabled_clear_a: assert property ( // RULE2
      @(posedge pclk) disable iff (!presetn) (ce && !buffer_enable) |=> (level_q == '0 && empty))
      else $error("buffer holds data while disabled");
   bypass_empty_a: assert property ( // RULE9
      @(posedge pclk) disable iff (!presetn)
      (ce && behav == bh_bypass && sample_valid) |=> (level_q == '0 && rd_idx_q == '0 && head_set == $past(in_set)))
      else $error("bypass did not keep the latest sample in the first slot");
   fifo_hold_a: assert property ( // RULE11
      @(posedge pclk) disable iff (!presetn)
      (ce && behav == bh_fifo && full && !pop && sample_valid) |=> ($stable(level_q) && $stable(wr_idx_q)))
      else $error("fifo mode accepted a set while full");
   halt_stays_a: assert property ( // RULE13
      @(posedge pclk) disable iff (!presetn) (ce && halted_q && behav == bh_fifo) |-> !push)
      else $error("collection resumed after the stop");
   stream_wrap_a: assert property ( // RULE17
      @(posedge pclk) disable iff (!presetn)
      (ce && behav == bh_stream && full && sample_valid && !pop_req)
      |=> ($stable(level_q) && rd_idx_q == $past(rd_idx_q) + 5'h01))
      else $error("stream overwrite did not drop the oldest set");
   wtm_set_a: assert property ( // RULE6
      @(posedge pclk) disable iff (!presetn)
      (ce && push && level_q >= {1'b0, watermark_threshold}) |=> watermark_flag_q)
      else $error("watermark flag missed an arrival at threshold");
   wtm_clear_a: assert property ( // RULE7
      @(posedge pclk) disable iff (!presetn)
      (ce && pop && !push && level_q <= {1'b0, watermark_threshold} + 6'h01) |=> !watermark_flag_q)
      else $error("watermark flag not cleared on readout");
   depth_limit_a: assert property ( // RULE15
      @(posedge pclk) disable iff (!presetn)
      (ce && behav == bh_fifo && watermark_enable) |-> ##0 (push |-> level_q <= {1'b0, watermark_threshold}))
      else $error("fifo grew past the watermark depth");
   count_sat_a: assert property ( // RULE21
      @(posedge pclk) disable iff (!presetn) (level_q == FULL_LEVEL) |-> (source_view[4:0] == LEVEL_SAT && full))
      else $error("full buffer shows wrong count or no overrun");
   pin_one_a: assert property ( // RULE16
      @(posedge pclk) disable iff (!presetn)
      (ce && first_irq_pin_enable && watermark_irq_route && watermark_flag_q) |=> accel_irq_pin_one)
      else $error("routed watermark missing on pin one");
   s2f_mode_a: assert property ( // RULE18
      @(posedge pclk) disable iff (!presetn)
      (buffer_enable && buffer_mode_field == CODE_S2F) |-> (behav == (trig ? bh_fifo : bh_stream)))
      else $error("stream-to-fifo ignored the trigger");
   pop_step_a: assert property ( // RULE19
      @(posedge pclk) disable iff (!presetn) (ce && pop) |=> rd_idx_q == $past(rd_idx_q) + 5'h01)
      else $error("readout did not advance to the next set");
endmodule : asf_sample_buffer

// ==== testbench/asf_host_model.sv ====
// Host processor model: APB master reaching the sample buffer registers
`timescale 1ns/1ps
module asf_host_model
   import asf_pkg::*;
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [asf_pkg::ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
   end

   // One transfer, request held until pready is seen high at an edge
   task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d, output logic [7:0] q,
                       output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= asf_byte_addr(idx);
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         asf_sample_buffer_tb.n_mismatch++;
         asf_sample_buffer_tb.test_done();
      end
   endtask : xfer

   // Register write; mode writes are how the host clears the buffer
   task automatic write(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      logic e;
      xfer(idx, 1'b1, d, q, e);
   endtask : write

   // Register read
   task automatic read(input logic [7:0] idx, output logic [7:0] q, output logic e);
      xfer(idx, 1'b0, 8'h00, q, e);
   endtask : read
endmodule : asf_host_model

// ==== testbench/asf_sample_buffer_tb.sv ====
// Self-checking bench for the accelerometer sample buffer
`timescale 1ns/1ps
module asf_sample_buffer_tb;
   import asf_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, pin_one, pin_two;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic sample_valid = 1'b0;
   logic [15:0] sx = 16'h0000, sy = 16'h0000, sz = 16'h0000;
   logic eng_one = 1'b0, eng_two = 1'b0;
   logic [47:0] sv_q;
   int n_mismatch = 0;
   int total_checks = 0;

   always #5 pclk = ~pclk;

   asf_sample_buffer i_asf_sample_buffer (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_valid(sample_valid), .sample_x(sx), .sample_y(sy), .sample_z(sz),
      .engine_one_irq_bit(eng_one), .engine_two_irq_bit(eng_two), .accel_irq_pin_one(pin_one),
      .accel_irq_pin_two(pin_two));
   asf_host_model i_asf_host_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Verdict and end of run
   task automatic test_done();
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // Compare and count
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Read a register and compare its byte
   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
      logic [7:0] q;
      logic e;
      i_asf_host_model.read(idx, q, e);
      chk(what, {40'h0, exp}, {40'h0, q});
   endtask : rchk

   // Sample set number k as {Z, Y, X}
   function automatic logic [47:0] set_of(input int k);
      return {8'h30, k[7:0], 8'h20, k[7:0], 8'h10, k[7:0]};
   endfunction : set_of

   // Push n sets back to back, numbered from first
   task automatic push(input int first, input int n);
      logic [47:0] s;
      for (int k = first; k < first + n; k++) begin
         s = set_of(k);
         @(posedge pclk);
         sample_valid <= 1'b1;
         sx <= s[15:0];
         sy <= s[31:16];
         sz <= s[47:32];
      end
      @(posedge pclk);
      sample_valid <= 1'b0;
   endtask : push

   // Burst read of the six output bytes
   task automatic get_set();
      logic [7:0] q;
      logic e;
      for (int b = 0; b < 6; b++) begin
         i_asf_host_model.read(IDX_OUT_XL + 8'(b), q, e);
         sv_q = {q, sv_q[47:8]};
      end
   endtask : get_set

   // Check a pin once its flag has had time to land
   task automatic pin_chk(input string what, input logic exp, input logic which);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk(what, {47'h0, exp}, {47'h0, which ? pin_two : pin_one});
   endtask : pin_chk

   // Configure through bypass first so the buffer starts clear
   task automatic cfg(input logic [7:0] bc, input logic [7:0] pc, input logic [2:0] m, input logic [4:0] t);
      i_asf_host_model.write(IDX_PIN_CTRL, pc);
      i_asf_host_model.write(IDX_BUF_CTRL, bc);
      i_asf_host_model.write(IDX_MODE_CTRL, {MODE_BYPASS, t});
      i_asf_host_model.write(IDX_MODE_CTRL, {m, t});
   endtask : cfg

   // Reset values and an unmapped address
   task automatic t_reset();
      logic [7:0] q;
      logic e;
      rchk(IDX_PIN_CTRL, PIN_CTRL_RST, "pin ctrl");
      rchk(IDX_BUF_CTRL, BUF_CTRL_RST, "buf ctrl");
      rchk(IDX_MODE_CTRL, MODE_CTRL_RST, "mode ctrl");
      rchk(IDX_SOURCE, 8'h20, "source at reset");
      i_asf_host_model.read(8'h30, q, e);
      chk("unmapped error", 48'h1, {47'h0, e});
      chk("unmapped data", 48'h0, {40'h0, q});
   endtask : t_reset

   // Buffer disabled: nothing stored
   task automatic t_disabled();
      cfg(8'h00, 8'h00, MODE_FIFO, 5'h1f);
      push(0, 3);
      rchk(IDX_SOURCE, 8'h20, "source disabled");
   endtask : t_disabled

   // Fifo mode fill, stop, overrun pin, restart
   task automatic t_fifo();
      cfg(8'h42, 8'h01, MODE_FIFO, 5'h1f);
      push(0, 32);
      rchk(IDX_SOURCE, 8'hdf, "source full");
      push(32, 1);
      pin_chk("overrun pin one", 1'b1, 1'b0);
      get_set();
      chk("fifo first set", set_of(0), sv_q);
      get_set();
      chk("fifo second set", set_of(1), sv_q);
      rchk(IDX_SOURCE, 8'h1e, "source after pops");
      cfg(8'h42, 8'h01, MODE_FIFO, 5'h1f);
      rchk(IDX_SOURCE, 8'h20, "source restart");
   endtask : t_fifo

   // Stream mode wraps over the oldest sets
   task automatic t_stream();
      cfg(8'h40, 8'h00, MODE_STREAM, 5'h1f);
      push(100, 34);
      rchk(IDX_SOURCE, 8'hdf, "source stream");
      get_set();
      chk("stream oldest", set_of(102), sv_q);
   endtask : t_stream

   // Watermark flag, pin routing and reduced depth
   task automatic t_wtm();
      cfg(8'h64, 8'h01, MODE_FIFO, 5'h03);
      push(50, 3);
      rchk(IDX_SOURCE, 8'h83, "source at mark");
      pin_chk("mark pin one", 1'b1, 1'b0);
      get_set();
      chk("mark set", set_of(50), sv_q);
      rchk(IDX_SOURCE, 8'h02, "source below mark");
      pin_chk("mark pin one low", 1'b0, 1'b0);
      push(53, 2);
      rchk(IDX_SOURCE, 8'hc4, "source depth");
   endtask : t_wtm

   // Bypass keeps only the latest set
   task automatic t_bypass();
      cfg(8'h40, 8'h00, MODE_BYPASS, 5'h1f);
      push(200, 2);
      rchk(IDX_SOURCE, 8'h20, "source bypass");
      get_set();
      chk("bypass latest", set_of(201), sv_q);
   endtask : t_bypass

   // Stream-to-fifo held as fifo by the engine bits; empty on pin two
   task automatic t_s2f();
      cfg(8'h40, 8'h06, MODE_S2F, 5'h1f);
      pin_chk("empty pin two", 1'b1, 1'b1);
      @(posedge pclk);
      eng_one <= 1'b1;
      push(150, 33);
      pin_chk("empty pin two low", 1'b0, 1'b1);
      get_set();
      chk("s2f first set", set_of(150), sv_q);
      eng_one <= 1'b0;
   endtask : t_s2f

   // Bypass-to-stream waits for a trigger; clock enable low freezes the buffer
   task automatic t_b2s();
      cfg(8'h40, 8'h0a, MODE_B2S, 5'h02);
      push(300, 2);
      rchk(IDX_SOURCE, 8'h20, "source before trigger");
      pin_chk("mark pin two idle", 1'b0, 1'b1);
      @(posedge pclk);
      eng_two <= 1'b1;
      @(posedge pclk);
      eng_two <= 1'b0;
      push(310, 3);
      @(posedge pclk);
      ce <= 1'b0;
      push(320, 2);
      ce <= 1'b1;
      rchk(IDX_SOURCE, 8'h83, "source after trigger");
      pin_chk("mark pin two", 1'b1, 1'b1);
      get_set();
      chk("b2s first set", set_of(310), sv_q);
   endtask : t_b2s

   // Main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_disabled();
      t_fifo();
      t_stream();
      t_wtm();
      t_bypass();
      t_s2f();
      t_b2s();
      test_done();
   end
endmodule : asf_sample_buffer_tb
